// ===== verilog/dcfg_top.sv
// Two-channel comparator variant and function generator configuration.
// Assumes a register decoder upstream delivering one-cycle strobes,
// all inputs synchronous to ref_clk_i.
//
// Function
// [R1] Two channels, each with own register pair
// [R2] Variant 00: plain comparator
// [R3] Variant 01: hysteresis from bound codes
// [R4] Variant 10: window between bound codes
// [R5] Host never writes variant 11
// [R6] Bit 15 clears to zero or mid-scale
// [R7] Bit 14 low: written code applies at once
// [R8] Bit 14 high: hold until load trigger
// [R9] Bit 13 accepts broadcast writes
// [R10] Phase field offsets waveform 0/120/240/90
// [R11] Shapes: triangle, sawtooth, inverse sawtooth
// [R12] Shape 100 sine, 111 off
// [R13] Bit 7 low selects linear slew
// [R14] Increment codes map to 1..32 LSB
// [R15] Interval 0000 jumps without slewing
// [R16] Host avoids interval 0000 with waveforms
// [R17] Interval codes set time per step
// [R18] Variant acts only when comparator enabled
// [R19] Bit 7 high: logarithmic 3.125% steps
// [R20] Bound codes left-aligned in bits 15-4
// [R21] Timer counts cycles, restarts on change
// [R22] Unused bits read zero, ignore writes
`timescale 1ns/1ps
`include "dcfg_cfg.svh"
`default_nettype none

module dcfg_top #(
    // Cycles per interval code; long counts may be shortened in simulation
    parameter int unsigned SLEW_CYC [16] = '{
        1,
        `DCFG_CYC(`DCFG_T01_NS), `DCFG_CYC(`DCFG_T02_NS),
        `DCFG_CYC(`DCFG_T03_NS), `DCFG_CYC(`DCFG_T04_NS),
        `DCFG_CYC(`DCFG_T05_NS), `DCFG_CYC(`DCFG_T06_NS),
        `DCFG_CYC(`DCFG_T07_NS), `DCFG_CYC(`DCFG_T08_NS),
        `DCFG_CYC(`DCFG_T09_NS), `DCFG_CYC(`DCFG_T10_NS),
        `DCFG_CYC(`DCFG_T11_NS), `DCFG_CYC(`DCFG_T12_NS),
        `DCFG_CYC(`DCFG_T13_NS), `DCFG_CYC(`DCFG_T13_NS),
        `DCFG_CYC(`DCFG_T13_NS)
    }
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rstn_i,
    input  wire logic             reg_wr_i,
    input  wire logic             reg_rd_i,
    input  wire logic [7:0]       reg_addr_i,
    input  wire logic [15:0]      reg_wdata_i,
    output logic      [15:0]      reg_rdata_o,
    input  wire logic [1:0]       data_wr_i,
    input  wire logic [15:0]      data_i,
    input  wire logic             bcast_wr_i,
    input  wire logic [15:0]      bcast_data_i,
    input  wire logic             load_trigger_n_i,
    input  wire logic             load_bit_i,
    input  wire logic [1:0]       clear_i,
    input  wire logic [1:0][15:0] bound_hi_i,
    input  wire logic [1:0][15:0] bound_lo_i,
    input  wire logic [1:0]       comparator_enable_i,
    input  wire logic [1:0]       iout_pdn_i,
    input  wire logic [1:0]       vout_en_i,
    output logic      [1:0][11:0] dac_code_o,
    output logic      [1:0]       hyst_en_o,
    output logic      [1:0]       window_en_o
);
    import dcfg_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Functions

    // Address decode: {hit, channel, is function register}
    function automatic logic [2:0] decode(input logic [7:0] a);
        unique case (a)
            `DCFG_ADDR_CMP_A:  decode = 3'h4;
            `DCFG_ADDR_FUNC_A: decode = 3'h5;
            `DCFG_ADDR_CMP_B:  decode = 3'h6;
            `DCFG_ADDR_FUNC_B: decode = 3'h7;
            default:           decode = 3'h0;
        endcase
    endfunction

    // Code change per linear step
    function automatic logic [5:0] inc_lut(input logic [2:0] k);
        unique case (k)
            3'h0: inc_lut = 6'h01;
            3'h1: inc_lut = 6'h02;
            3'h2: inc_lut = 6'h03;
            3'h3: inc_lut = 6'h04;
            3'h4: inc_lut = 6'h06;
            3'h5: inc_lut = 6'h08;
            3'h6: inc_lut = 6'h10;
            3'h7: inc_lut = 6'h20;
        endcase
    endfunction

    // Logarithmic interval field to the matching linear interval code
    function automatic logic [3:0] log_code(input logic [2:0] k);
        unique case (k)
            3'h0: log_code = 4'h1;
            3'h1: log_code = 4'h3;
            3'h2: log_code = 4'h5;
            3'h3: log_code = 4'h7;
            3'h4: log_code = 4'h9;
            3'h5: log_code = 4'hA;
            3'h6: log_code = 4'hC;
            3'h7: log_code = 4'hD;
        endcase
    endfunction

    // Phase to 12-bit fraction of the span, per shape
    function automatic logic [11:0] shape_fn(input logic [2:0] sh,
                                             input logic [12:0] e);
        logic [11:0] tri_v;
        logic [23:0] p2;
        logic [23:0] p3;
        logic [13:0] s;
        tri_v = e[12] ? ~e[11:0] : e[11:0];
        p2 = tri_v * tri_v;
        p3 = p2[23:12] * tri_v;
        s = 14'(3 * p2[23:12]) - 14'(2 * p3[23:12]);
        unique case (sh)
            DCFG_SH_SAW: shape_fn = e[11:0];                      // [R11]
            DCFG_SH_INV: shape_fn = ~e[11:0];                     // [R11]
            // Smoothstep of the triangle stands in for a sine table
            DCFG_SH_SIN: shape_fn = s[13:12] != 2'h0 ? 12'hFFF
                                                     : s[11:0];   // [R12]
            default:     shape_fn = tri_v;                        // [R11]
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // State

    dcfg_state_t st;       // Registered state
    dcfg_state_t next_st;  // Next state

    // Working values, written only by the next-state process
    logic [1:0][2:0]  dec_w;    // Decode of register address
    logic [1:0][3:0]  icode;    // Active interval code
    logic [1:0]       tick;     // Step strobe
    logic [1:0][12:0] eff_ph;   // Phase with offset
    logic [1:0][11:0] hi;       // Upper bound code
    logic [1:0][11:0] lo;       // Lower bound code
    logic [1:0][11:0] span;     // Upper minus lower
    logic [1:0][23:0] prod;     // Span scaled by shape
    logic [1:0][12:0] sum;      // Code plus or minus step
    logic [1:0][11:0] step;     // Step size
    logic [1:0]       up;       // Moving upward
    logic             trig;     // Load event

    ////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_st = st;
        dec_w = '0;
        icode = '0;
        tick = '0;
        eff_ph = '0;
        hi = '0;
        lo = '0;
        span = '0;
        prod = '0;
        sum = '0;
        step = '0;
        up = '0;
        // Falling edge of the pin or the software load bit
        trig = (st.trig_q & ~load_trigger_n_i) | load_bit_i;       // [R8]
        next_st.trig_q = load_trigger_n_i;
        next_st.rdata = '0;
        for (int c = 0; c < 2; c++) begin                          // [R1]
            dec_w[c] = decode(reg_addr_i);
            // Register writes; only defined fields are stored
            if (reg_wr_i && dec_w[c][2] && dec_w[c][1] == 1'(c)) begin
                if (dec_w[c][0]) begin
                    next_st.ch[c].func = reg_wdata_i;
                end else begin
                    next_st.ch[c].cmp_mode =
                        reg_wdata_i[`DCFG_CMP_LSB+1:`DCFG_CMP_LSB]; // [R22]
                end
            end
            // Register reads, undefined bits as zero
            if (reg_rd_i && dec_w[c][2] && dec_w[c][1] == 1'(c)) begin
                next_st.rdata = dec_w[c][0] ? st.ch[c].func
                    : 16'({st.ch[c].cmp_mode, 10'h000});           // [R22]
            end
            // Comparator variant gated by enable and output modes
            next_st.ch[c].hyst = comparator_enable_i[c] & iout_pdn_i[c]
                & vout_en_i[c] & (st.ch[c].cmp_mode == DCFG_CMP_HYST); // [R3] [R18]
            next_st.ch[c].win = comparator_enable_i[c] & iout_pdn_i[c]
                & vout_en_i[c] & (st.ch[c].cmp_mode == DCFG_CMP_WIN);  // [R4] [R18]
            // Plain mode and 11 leave both off                       [R2]
            // Deferred codes move across on a load event
            if (trig && st.ch[c].pend_v) begin
                next_st.ch[c].target = st.ch[c].pend;              // [R8]
                next_st.ch[c].pend_v = 1'b0;
            end
            // Direct or broadcast code write
            if (data_wr_i[c] || (bcast_wr_i && st.ch[c].func[`DCFG_BRD_BIT])) begin // [R9]
                if (st.ch[c].func[`DCFG_SYNC_BIT]) begin
                    next_st.ch[c].pend = data_wr_i[c] ? data_i[15:4]
                                                      : bcast_data_i[15:4]; // [R8]
                    next_st.ch[c].pend_v = 1'b1;
                end else begin
                    next_st.ch[c].target = data_wr_i[c] ? data_i[15:4]
                                                        : bcast_data_i[15:4]; // [R7]
                end
            end
            // Bound codes, low nibble ignored
            hi[c] = bound_hi_i[c][15:`DCFG_CODE_LSB];              // [R20]
            lo[c] = bound_lo_i[c][15:`DCFG_CODE_LSB];              // [R20]
            span[c] = hi[c] >= lo[c] ? hi[c] - lo[c] : 12'h000;
            up[c] = st.ch[c].target > st.ch[c].code;
            // Interval code per slew style
            if (st.ch[c].func[`DCFG_LOG_BIT]) begin
                icode[c] = log_code(up[c] ? st.ch[c].func[6:4]
                                          : st.ch[c].func[3:1]);   // [R19]
            end else begin
                icode[c] = st.ch[c].func[3:0];                     // [R13]
            end
            // Step timer restarts whenever the interval code changes
            if (icode[c] != st.ch[c].icode_q) begin
                next_st.ch[c].icode_q = icode[c];
                next_st.ch[c].tmr = 21'(SLEW_CYC[icode[c]] - 1);  // [R21]
            end else if (st.ch[c].tmr == 21'h000000) begin
                next_st.ch[c].tmr = 21'(SLEW_CYC[icode[c]] - 1);  // [R17]
                tick[c] = 1'b1;
            end else begin
                next_st.ch[c].tmr = st.ch[c].tmr - 21'h000001;
            end
            // Waveform generation or slewing toward the target
            if (st.ch[c].func[10:8] != DCFG_SH_OFF) begin
                // Interval 0000 is not a valid generator setting; hold
                if (icode[c] != 4'h0 && tick[c]) begin             // [R16]
                    next_st.ch[c].ph = st.ch[c].ph
                        + 13'(inc_lut(st.ch[c].func[6:4]));        // [R14]
                end
                unique case (st.ch[c].func[12:11])
                    2'h0: eff_ph[c] = st.ch[c].ph + `DCFG_PH_0;    // [R10]
                    2'h1: eff_ph[c] = st.ch[c].ph + `DCFG_PH_120;  // [R10]
                    2'h2: eff_ph[c] = st.ch[c].ph + `DCFG_PH_240;  // [R10]
                    2'h3: eff_ph[c] = st.ch[c].ph + `DCFG_PH_90;   // [R10]
                endcase
                prod[c] = span[c] * shape_fn(st.ch[c].func[10:8], eff_ph[c]);
                next_st.ch[c].code = lo[c] + prod[c][23:12];       // [R12]
            end else if (icode[c] == 4'h0) begin
                next_st.ch[c].code = st.ch[c].target;              // [R15]
            end else if (tick[c] && st.ch[c].code != st.ch[c].target) begin
                if (st.ch[c].func[`DCFG_LOG_BIT]) begin
                    // Step is 1/32 of the present code, at least one LSB
                    step[c] = st.ch[c].code[11:5] == 7'h00 ? 12'h001
                                : 12'(st.ch[c].code[11:5]);        // [R19]
                end else begin
                    step[c] = 12'(inc_lut(st.ch[c].func[6:4]));    // [R14]
                end
                if (up[c]) begin
                    sum[c] = 13'(st.ch[c].code) + 13'(step[c]);
                    next_st.ch[c].code = sum[c] > 13'(st.ch[c].target)
                        ? st.ch[c].target : sum[c][11:0];          // [R13]
                end else begin
                    sum[c] = 13'(st.ch[c].code) - 13'(step[c]);
                    next_st.ch[c].code = (sum[c][12]
                        || sum[c][11:0] < st.ch[c].target)
                        ? st.ch[c].target : sum[c][11:0];          // [R13]
                end
            end
            // Clear overrides every other code source
            if (clear_i[c]) begin
                next_st.ch[c].code = st.ch[c].func[`DCFG_CLR_BIT]
                    ? `DCFG_MID_CODE : `DCFG_ZERO_CODE;            // [R6]
                next_st.ch[c].target = next_st.ch[c].code;
                next_st.ch[c].pend_v = 1'b0;
                next_st.ch[c].ph = '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register with synchronous reset
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            st <= '0;
            st.ch[0].func <= `DCFG_RST_VAL;
            st.ch[1].func <= `DCFG_RST_VAL;
            st.trig_q <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs straight from state
    assign reg_rdata_o = st.rdata;
    assign dac_code_o[0] = st.ch[0].code;
    assign dac_code_o[1] = st.ch[1].code;
    assign hyst_en_o = {st.ch[1].hyst, st.ch[0].hyst};
    assign window_en_o = {st.ch[1].win, st.ch[0].win};

endmodule // dcfg_top

`default_nettype wire

// ===== verilog/dcfg_cfg.svh
// Constants for the per-channel comparator and function configuration block.
// Assumes a 200 MHz core clock and 16-bit registers.
`ifndef DCFG_CFG_SVH
`define DCFG_CFG_SVH
// Register addresses, one pair per channel
`define DCFG_ADDR_CMP_A  8'h05
`define DCFG_ADDR_FUNC_A 8'h06
`define DCFG_ADDR_CMP_B  8'h17
`define DCFG_ADDR_FUNC_B 8'h18
// Field positions
`define DCFG_CMP_LSB   10
`define DCFG_CLR_BIT   15
`define DCFG_SYNC_BIT  14
`define DCFG_BRD_BIT   13
`define DCFG_LOG_BIT   7
`define DCFG_CODE_LSB  4
// Reset and clear values
`define DCFG_RST_VAL   16'h0000
`define DCFG_ZERO_CODE 12'h000
`define DCFG_MID_CODE  12'h800
// Phase offsets on a 8192-unit waveform period
`define DCFG_PH_0      13'h0000
`define DCFG_PH_120    13'h0AAB
`define DCFG_PH_240    13'h1555
`define DCFG_PH_90     13'h0800
// Clock rate and step interval times in ns
`define DCFG_CLK_MHZ   200
`define DCFG_T01_NS    4000
`define DCFG_T02_NS    8000
`define DCFG_T03_NS    12000
`define DCFG_T04_NS    18000
`define DCFG_T05_NS    27040
`define DCFG_T06_NS    40480
`define DCFG_T07_NS    60720
`define DCFG_T08_NS    91120
`define DCFG_T09_NS    136720
`define DCFG_T10_NS    418640
`define DCFG_T11_NS    732560
`define DCFG_T12_NS    1282000
`define DCFG_T13_NS    5127920
`define DCFG_CYC(ns)   ((ns) * `DCFG_CLK_MHZ / 1000)
`endif

// ===== verilog/dcfg_pkg.sv
// Types shared by the configuration block.
// Assumes dcfg_cfg.svh is on the include path.
`default_nettype none
package dcfg_pkg;
    // Waveform shape codes
    typedef enum logic [2:0] {
        DCFG_SH_TRI = 3'h0,
        DCFG_SH_SAW = 3'h1,
        DCFG_SH_INV = 3'h2,
        DCFG_SH_SIN = 3'h4,
        DCFG_SH_OFF = 3'h7
    } dcfg_shape_t;
    // Comparator variant codes
    typedef enum logic [1:0] {
        DCFG_CMP_PLAIN = 2'h0,
        DCFG_CMP_HYST  = 2'h1,
        DCFG_CMP_WIN   = 2'h2
    } dcfg_cmp_t;
    // Per-channel state
    typedef struct packed {
        logic [1:0]  cmp_mode;  // Comparator variant field
        logic [15:0] func;      // Function register
        logic [11:0] pend;      // Code held for a load trigger
        logic        pend_v;    // Held code present
        logic [11:0] target;    // Code the output moves to
        logic [11:0] code;      // Code driven out
        logic [12:0] ph;        // Waveform phase
        logic [20:0] tmr;       // Step interval timer
        logic [3:0]  icode_q;   // Interval code the timer runs on
        logic        hyst;      // Hysteresis active
        logic        win;       // Window active
    } dcfg_chan_t;
    // Whole block state
    typedef struct packed {
        dcfg_chan_t [1:0] ch;
        logic [15:0]      rdata;
        logic             trig_q;  // Last load trigger level
    } dcfg_state_t;
endpackage
`default_nettype wire

// ===== tb/dcfg_top_sva.sv
// Port checker for the two-channel comparator and function configuration block.
// Assumes it is bound to dcfg_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module dcfg_top_sva (
    input wire logic             ref_clk_i,
    input wire logic             rstn_i,
    input wire logic             reg_wr_i,
    input wire logic             reg_rd_i,
    input wire logic [7:0]       reg_addr_i,
    input wire logic [15:0]      reg_wdata_i,
    input wire logic [15:0]      reg_rdata_o,
    input wire logic [1:0]       data_wr_i,
    input wire logic [15:0]      data_i,
    input wire logic             bcast_wr_i,
    input wire logic [1:0]       clear_i,
    input wire logic [1:0]       comparator_enable_i,
    input wire logic [1:0]       iout_pdn_i,
    input wire logic [1:0]       vout_en_i,
    input wire logic [1:0][11:0] dac_code_o,
    input wire logic [1:0]       hyst_en_o,
    input wire logic [1:0]       window_en_o
);
    ////////////////////////////////////////////////////////////////////////
    logic [15:0] func0;  // Shadow of channel 0 function register
    logic [15:0] func1;  // Shadow of channel 1 function register
    logic [1:0]  cmp0;   // Shadow of channel 0 variant field
    wire  logic  imm0 = !func0[14] && func0[10:8] == 3'h7 && !func0[7] && func0[3:0] == 4'h0;

    // Shadows follow host writes so checks need not peek inside the block
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            func0 <= 16'h0000;
            func1 <= 16'h0000;
            cmp0  <= 2'h0;
        end else if (reg_wr_i) begin
            if (reg_addr_i == 8'h06) func0 <= reg_wdata_i;
            if (reg_addr_i == 8'h18) func1 <= reg_wdata_i;
            if (reg_addr_i == 8'h05) cmp0 <= reg_wdata_i[11:10];
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    ////////////////////////////////////////////////////////////////////////
    cmp_rsvd_a: assert property (
        reg_rd_i && (reg_addr_i == 8'h05 || reg_addr_i == 8'h17)
        |=> (reg_rdata_o & 16'hF3FF) == 16'h0000) else $error("variant spare bits not zero");
    unmapped_rd_a: assert property (
        reg_rd_i && !(reg_addr_i inside {8'h05, 8'h06, 8'h17, 8'h18})
        |=> reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
    func_rdback_a: assert property (
        reg_rd_i && reg_addr_i == 8'h18 |=> reg_rdata_o == $past(func1))
        else $error("channel 1 function readback wrong");
    plain_mode_a: assert property (
        cmp0 == 2'h0 && $past(cmp0) == 2'h0 |-> !hyst_en_o[0] && !window_en_o[0])
        else $error("plain variant shows hysteresis or window");
    hyst_mode_a: assert property (
        hyst_en_o[0] |-> cmp0 == 2'h1 || $past(cmp0) == 2'h1)
        else $error("hysteresis without variant 01");
    window_mode_a: assert property (
        window_en_o[0] |-> cmp0 == 2'h2 || $past(cmp0) == 2'h2)
        else $error("window without variant 10");
    cmp_gate_a: assert property (
        ((hyst_en_o | window_en_o) & ~$past(comparator_enable_i & iout_pdn_i & vout_en_i))
        == 2'b00) else $error("variant active while comparator not enabled");
    clear_lvl_a: assert property (
        clear_i[0] |=> dac_code_o[0] == ($past(func0[15]) ? 12'h800 : 12'h000))
        else $error("clear level wrong");
    imm_update_a: assert property (
        data_wr_i[0] && imm0 && !bcast_wr_i && !clear_i[0] ##1 !clear_i[0]
        |=> dac_code_o[0] == $past(data_i[15:4], 2)) else $error("code not applied");

    // Main scenarios reached
    cover property (hyst_en_o[0]);
    cover property (window_en_o[0]);
    cover property (clear_i[0] && func0[15]);
    cover property (data_wr_i[0] && func0[14]);
endmodule // dcfg_top_sva
`default_nettype wire

// ===== tb/dcfg_host_model.sv
// Host model: issues one register write or read at a time on the strobe bus.
// Assumes one-cycle strobes and read data registered one cycle after the read.
`timescale 1ns/1ps
`default_nettype none
module dcfg_host_model (
    input  wire logic        ref_clk_i,
    input  wire logic [15:0] reg_rdata_i,
    output var  logic        reg_wr_o,
    output var  logic        reg_rd_o,
    output var  logic [7:0]  reg_addr_o,
    output var  logic [15:0] reg_wdata_o
);
    // Idle bus at time zero
    initial begin
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_addr_o  = 8'h00;
        reg_wdata_o = 16'h0000;
    end

    // Write; variant code 11 is never sent, it is cleared to plain
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        #1;
        reg_addr_o  = a;
        reg_wdata_o = ((a == 8'h05 || a == 8'h17) && d[11:10] == 2'h3) ? d & 16'hF3FF : d;
        reg_wr_o    = 1'b1;
        @(posedge ref_clk_i);
        #1;
        reg_wr_o    = 1'b0;
        reg_addr_o  = ~a;  // Released lines never keep the last value
        reg_wdata_o = ~d;
    endtask

    // Read; data is taken in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge ref_clk_i);
        #1;
        reg_addr_o = a;
        reg_rd_o   = 1'b1;
        @(posedge ref_clk_i);
        #1;
        d          = reg_rdata_i;
        reg_rd_o   = 1'b0;
        reg_addr_o = ~a;
    endtask
endmodule // dcfg_host_model
`default_nettype wire

// ===== tb/dac_cmp_mode_and_func_gen_cfg_test.sv
// Self-checking bench for the two-channel configuration block.
// Assumes the host model and port checker files compile before this one.
`timescale 1ns/1ps
`default_nettype none
module dac_cmp_mode_and_func_gen_cfg_test;
    logic             clk       = 1'b0;
    logic             rstn      = 1'b0;
    logic             reg_wr;
    logic             reg_rd;
    logic [7:0]       reg_addr;
    logic [15:0]      reg_wdata;
    logic [15:0]      reg_rdata;
    logic [1:0]       data_wr   = 2'b00;
    logic [15:0]      data_val  = 16'h0000;
    logic             bcast_wr  = 1'b0;
    logic [15:0]      bcast_val = 16'h0000;
    logic             load_n    = 1'b1;  // Pin idles high
    logic             load_bit  = 1'b0;
    logic [1:0]       clear     = 2'b00;
    logic [1:0][15:0] bound_hi  = {16'hC000, 16'hC000};
    logic [1:0][15:0] bound_lo  = {16'h4000, 16'h4000};
    logic [1:0]       cmp_en    = 2'b00;
    logic [1:0]       iout_pdn  = 2'b00;
    logic [1:0]       vout_en   = 2'b00;
    logic [1:0][11:0] dac_code;
    logic [1:0]       hyst_en;
    logic [1:0]       window_en;
    int               miscompares     = 0;
    int               samples_checked = 0;

    // 200 MHz clock
    always #2.5 clk = ~clk;

    dcfg_host_model dcfg_host_model_i (.ref_clk_i(clk), .reg_rdata_i(reg_rdata),
        .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));

    dcfg_top dcfg_top_i (.ref_clk_i(clk), .rstn_i(rstn), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
        .data_wr_i(data_wr), .data_i(data_val), .bcast_wr_i(bcast_wr), .bcast_data_i(bcast_val),
        .load_trigger_n_i(load_n), .load_bit_i(load_bit), .clear_i(clear),
        .bound_hi_i(bound_hi), .bound_lo_i(bound_lo), .comparator_enable_i(cmp_en),
        .iout_pdn_i(iout_pdn), .vout_en_i(vout_en), .dac_code_o(dac_code),
        .hyst_en_o(hyst_en), .window_en_o(window_en));

    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        dcfg_host_model_i.rd(a, d);
        chk(d, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        dcfg_host_model_i.wr(a, d);
    endtask
    // One-cycle code write pulse; new code shows one edge after return
    task automatic code_wr(input logic [1:0] ch, input logic [15:0] d);
        data_val = d;
        data_wr  = ch;
        tick(1);
        data_wr  = 2'b00;
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rdchk(8'h05, 16'h0000);
        rdchk(8'h06, 16'h0000);
        rdchk(8'h17, 16'h0000);
        rdchk(8'h18, 16'h0000);
        wr(8'h05, 16'hF7FF);
        rdchk(8'h05, 16'h0400);
        wr(8'h18, 16'hA4C3);
        rdchk(8'h18, 16'hA4C3);
        rdchk(8'h06, 16'h0000);
        rdchk(8'h07, 16'h0000);
    endtask
    task automatic t_cmp();
        {cmp_en, iout_pdn, vout_en} = 6'h3F;
        for (int m = 0; m < 3; m++) begin
            wr(8'h05, {4'h0, 2'(m), 10'h000});
            tick(3);
            chk({14'h0, hyst_en}, {15'h0, m == 1});
            chk({14'h0, window_en}, {15'h0, m == 2});
        end
        vout_en = 2'b00;
        tick(3);
        chk({14'h0, window_en}, 16'h0000);
    endtask
    task automatic t_code();
        wr(8'h06, 16'h0700);  // Generation off, so interval 0000 is allowed
        code_wr(2'b01, 16'hABC5);
        tick(1);
        chk({4'h0, dac_code[0]}, 16'h0ABC);
        wr(8'h06, 16'h4700);
        code_wr(2'b01, 16'h1230);
        tick(4);
        chk({4'h0, dac_code[0]}, 16'h0ABC);
        load_n = 1'b0;
        tick(2);
        chk({4'h0, dac_code[0]}, 16'h0123);
        load_n = 1'b1;
        code_wr(2'b01, 16'h4560);
        load_bit = 1'b1;
        tick(1);
        load_bit = 1'b0;
        tick(1);
        chk({4'h0, dac_code[0]}, 16'h0456);
    endtask
    task automatic t_bcast_clear();
        wr(8'h06, 16'h2700);
        wr(8'h18, 16'h0700);
        code_wr(2'b10, 16'h3330);
        bcast_val = 16'h7770;
        bcast_wr  = 1'b1;
        tick(1);
        bcast_wr  = 1'b0;
        tick(1);
        chk({4'h0, dac_code[0]}, 16'h0777);
        chk({4'h0, dac_code[1]}, 16'h0333);
        wr(8'h06, 16'h8700);
        clear = 2'b11;
        tick(1);
        clear = 2'b00;
        chk({4'h0, dac_code[0]}, 16'h0800);
        chk({4'h0, dac_code[1]}, 16'h0000);
    endtask
    // Linear slew from mid-scale: 32 LSB per step, 800 cycles (4 us) per step
    task automatic t_slew();
        wr(8'h06, 16'h0771);
        code_wr(2'b01, 16'h8400);
        tick(1);
        chk({4'h0, dac_code[0]}, 16'h0800);
        tick(800);
        chk({4'h0, dac_code[0]}, 16'h0820);
    endtask

    // Main sequence: reset held for 16 cycles, then the scenarios
    initial begin
        tick(16);
        rstn = 1'b1;
        tick(1);
        t_regs();
        t_cmp();
        t_code();
        t_bcast_clear();
        t_slew();
        wrap_up();
    end

    // Watchdog: the scenarios need about a thousand cycles, allow about 2000
    initial begin
        #10000;
        miscompares++;
        wrap_up();
    end
endmodule // dac_cmp_mode_and_func_gen_cfg_test

bind dcfg_top dcfg_top_sva dcfg_top_sva_i (.ref_clk_i, .rstn_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .data_wr_i, .data_i, .bcast_wr_i, .clear_i,
    .comparator_enable_i, .iout_pdn_i, .vout_en_i, .dac_code_o, .hyst_en_o, .window_en_o);
`default_nettype wire
